// >>> fsc_consts.svh
// fsc_consts.svh: bit positions, reset values and format constants of the fp control/status block
// assumes inclusion by bare name from the design files; the package does not include it
`ifndef FSC_CONSTS_SVH
`define FSC_CONSTS_SVH

// control/status register field positions
`define FSC_CC_HI_LSB 25
`define FSC_CC_HI_W 7
`define FSC_FS_BIT 24
`define FSC_CC0_BIT 23
`define FSC_CAUSE_LSB 12
`define FSC_CAUSE_W 6
`define FSC_EN_LSB 7
`define FSC_EN_W 5
`define FSC_FLAG_LSB 2
`define FSC_FLAG_W 5
`define FSC_RM_LSB 0
`define FSC_RM_W 2

// position of the unimplemented bit inside the cause field
`define FSC_CAUSE_UNIMPL 5

// reset values
`define FSC_RST_CC 8'h00
`define FSC_RST_FS 1'b0
`define FSC_RST_CAUSE 6'h00
`define FSC_RST_EN 5'h00
`define FSC_RST_FLAG 5'h00
`define FSC_RST_RM 2'h0

// single format: sign, 8-bit exponent, 23 stored fraction bits
`define FSC_SP_SIGN_BIT 31
`define FSC_SP_EXP_LSB 23
`define FSC_SP_EXP_W 8
`define FSC_SP_FRAC_W 23
`define FSC_SP_BIAS 13'h007f

// double format: sign, 11-bit exponent, 52 stored fraction bits
`define FSC_DP_SIGN_BIT 63
`define FSC_DP_EXP_LSB 52
`define FSC_DP_EXP_W 11
`define FSC_DP_FRAC_W 52
`define FSC_DP_BIAS 13'h03ff

// integer quiet-nan results: largest positive value
`define FSC_QNAN_WORD 32'h7fffffff
`define FSC_QNAN_LONG 64'h7fffffffffffffff

`endif

// >>> fsc_operand_class.sv
// fsc_operand_class.sv: classifies one fp operand and flushes denormals to zero
// assumes a single operand sits in the low word; results appear one cycle later
`include "fsc_consts.svh"
module fsc_operand_class
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // operand in
  input wire logic i_valid,
  input wire logic i_double,
  input wire logic i_flush_en,
  input wire logic [63:0] i_operand,
  // classified operand out
  output logic o_valid,
  output fsc_pkg::fsc_class_t o_class,
  output logic o_sign,
  output logic [12:0] o_exp_unb,
  output logic [63:0] o_operand
);
  import fsc_pkg::*;

  logic sign;
  logic [10:0] exp_field;
  logic exp_ones;
  logic exp_zero;
  logic frac_nz;
  logic frac_msb;
  logic [12:0] bias;
  fsc_class_t cls;
  logic [63:0] operand_eff;

  // field extraction for both widths
  always_comb
  begin
    if (i_double)
    begin
      sign = i_operand[`FSC_DP_SIGN_BIT]; // RULE_19
      exp_field = i_operand[`FSC_DP_EXP_LSB +: `FSC_DP_EXP_W];
      frac_nz = |i_operand[`FSC_DP_FRAC_W-1:0];
      frac_msb = i_operand[`FSC_DP_FRAC_W-1];
      bias = `FSC_DP_BIAS;
      exp_ones = &exp_field;
    end
    else
    begin
      sign = i_operand[`FSC_SP_SIGN_BIT]; // RULE_18
      exp_field = {3'h0, i_operand[`FSC_SP_EXP_LSB +: `FSC_SP_EXP_W]};
      frac_nz = |i_operand[`FSC_SP_FRAC_W-1:0];
      frac_msb = i_operand[`FSC_SP_FRAC_W-1];
      bias = `FSC_SP_BIAS;
      exp_ones = &exp_field[`FSC_SP_EXP_W-1:0];
    end
    exp_zero = ~|exp_field;
  end

  // class decode; a set fraction msb marks the signaling kind here
  always_comb
  begin
    if (exp_ones)
      cls = frac_nz ? (frac_msb ? FSC_CLS_SNAN : FSC_CLS_QNAN) : FSC_CLS_INF; // RULE_20 RULE_21
    else if (exp_zero)
      cls = frac_nz ? FSC_CLS_DENORM : FSC_CLS_ZERO; // RULE_20
    else
      cls = FSC_CLS_NORMAL;
  end

  // denormal input replaced by a zero of the same sign, only when asked
  always_comb
  begin
    operand_eff = i_operand;
    if (i_flush_en && cls == FSC_CLS_DENORM)
      operand_eff = i_double ? {sign, 63'h0} : {32'h0, sign, 31'h0}; // RULE_03
  end

  // registered outputs
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      o_valid <= 1'b0;
      o_class <= FSC_CLS_ZERO;
      o_sign <= 1'b0;
      o_exp_unb <= 13'h0000;
      o_operand <= 64'h0;
    end
    else
    begin
      o_valid <= i_valid;
      o_class <= cls;
      o_sign <= sign;
      // zero and denormal share the minimum exponent, one above the reserved code
      o_exp_unb <= exp_zero ? (13'h0001 - bias) : ({2'h0, exp_field} - bias);
      o_operand <= operand_eff;
    end
  end

  // a flushed denormal leaves only its sign
  a_denorm_zeroed: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (i_flush_en && cls == FSC_CLS_DENORM && !i_double)
    |=> (o_operand[30:0] == 31'h0 && o_class == FSC_CLS_DENORM)) // RULE_03
    else $error("denormal single operand not flushed");

endmodule : fsc_operand_class

// >>> fsc_pipe_model.sv
// fsc_pipe_model.sv: integer pipeline that reports completing fp instructions
// assumes every call starts just after a falling clock edge
module fsc_pipe_model
  import fsc_pkg::*;
(
  // clock and answers of the block
  input wire logic i_clock,
  input wire logic [2:0] i_answer,
  // completion report
  output logic o_ops_pending,
  output logic o_op_done,
  output fsc_op_kind_t o_op_kind,
  output logic [11:0] o_op_info
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle between instructions; the report is only qualified by the done pulse
  initial
  begin
    {o_ops_pending, o_op_done, o_op_info} = '0;
    o_op_kind = FSC_OP_MOVE;
  end
  // one instruction completes for one clock; answers are combinational, so sampled before the edge
  task issue(input fsc_op_kind_t k, input logic [11:0] info, output logic [2:0] ans);
    o_op_kind = k;
    o_op_info = info;
    o_op_done = 1'h1;
    #1 ans = i_answer;
    @(negedge i_clock);
    o_op_done = 1'h0;
  endtask : issue
endmodule : fsc_pipe_model

// >>> fsc_pkg.sv
// fsc_pkg.sv: types shared by the fp control/status block
// assumes fsc_consts.svh is on the include path
package fsc_pkg;

  // kind of a completing coprocessor instruction
  typedef enum logic [1:0] {
    FSC_OP_ARITH,
    FSC_OP_CONVERT,
    FSC_OP_COMPARE,
    FSC_OP_MOVE
  } fsc_op_kind_t;

  // rounding selection, in the order of its two-bit encoding
  typedef enum logic [1:0] {
    FSC_ROUND_NEAREST_EVEN,
    FSC_ROUND_TOWARD_ZERO,
    FSC_ROUND_TOWARD_PLUS_INF,
    FSC_ROUND_TOWARD_MINUS_INF
  } fsc_round_t;

  // operand classes
  typedef enum logic [2:0] {
    FSC_CLS_ZERO,
    FSC_CLS_DENORM,
    FSC_CLS_NORMAL,
    FSC_CLS_INF,
    FSC_CLS_QNAN,
    FSC_CLS_SNAN
  } fsc_class_t;

  // move-control read sequencer
  typedef enum logic {
    FSC_RD_IDLE,
    FSC_RD_WAIT
  } fsc_rd_state_t;

endpackage : fsc_pkg

// >>> fsc_status.sv
// fsc_status.sv: fp control/status register, cause/flag/enable handling and trap decision
// assumes the integer pipeline reports each completing fp instruction in one cycle,
// and holds i_ops_pending while any fp instruction is still in flight
`include "fsc_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// RULE_01: with flushing on, a denormal arithmetic result becomes zero, no unimplemented trap.
// RULE_02: software keeps underflow and inexact enables clear when flushing.
// RULE_03: with flushing on, denormal arithmetic source operands are taken as zero.
// RULE_04: flushing acts on arithmetic only; loads, stores, moves ignore it.
// RULE_05: a compare writes true or false into one of eight condition bits.
// RULE_06: condition bits change only by compare or move-control write.
// RULE_07: cause field shows every exception of the latest fp operation.
// RULE_08: each fp operation rewrites the whole cause field; moves leave it.
// RULE_09: unimplemented cause is one when emulation is needed, else zero.
// RULE_10: a trapping operation writes no destination; only cause changes.
// RULE_11: cause and matching enable both set raise an exception at once.
// RULE_12: unimplemented cause has no enable and always raises an exception.
// RULE_13: the handler clears enabled cause bits by move-control write before return.
// RULE_14: causes with clear enables do not trap; default result is stored.
// RULE_15: flags are sticky, set on untrapped exceptions, cleared only by writes.
// RULE_16: a trapping operation leaves the flags untouched.
// RULE_17: two-bit rounding field selects nearest-even, zero, plus or minus infinity.
// RULE_18: single operand: sign, 8-bit exponent biased by 127, 23-bit fraction.
// RULE_19: double operand: sign, 11-bit exponent biased by 1023, fraction.
// RULE_20: exponent all ones gives nan or infinity, all zeros denormal or zero.
// RULE_21: nan with fraction msb set is signaling, clear is quiet.
// RULE_22: integer invalid result is the largest positive value, word and long.
// RULE_23: fused multiply-add with denormal product always traps as unimplemented.
// RULE_24: move-control read waits for in-flight ops; a trap makes it re-execute.
// RULE_25: cause holds unimpl, invalid, divzero, overflow, underflow, inexact from the top.
module fsc_status
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // move-control write into the control/status register
  input wire logic i_move_ctl_to_fpu,
  input wire logic [31:0] i_move_ctl_to_fpu_data,
  // move-control read of the control/status register
  input wire logic i_move_ctl_from_fpu,
  output logic o_move_ctl_from_fpu_busy,
  output logic o_move_ctl_from_fpu_valid,
  output logic o_move_ctl_from_fpu_retry,
  output logic [31:0] o_move_ctl_from_fpu_data,
  // completing fp instruction from the pipeline
  input wire logic i_ops_pending,
  input wire logic i_op_done,
  input wire fsc_pkg::fsc_op_kind_t i_op_kind,
  input wire logic [5:0] i_op_exc,
  input wire logic i_op_res_denorm,
  input wire logic i_op_fma_mul_denorm,
  input wire logic i_op_writes_dest,
  input wire logic [2:0] i_op_cc_sel,
  input wire logic i_op_cc_true,
  // completion results
  output logic o_fp_trap,
  output logic o_trap_pending,
  output logic o_dest_wr_en,
  output logic o_flush_result_zero,
  // source operands for classification
  input wire logic i_opnd_valid,
  input wire logic i_opnd_double,
  input wire logic i_opnd_arith,
  input wire logic [63:0] i_opa,
  input wire logic [63:0] i_opb,
  output logic o_opnd_valid,
  output logic [63:0] o_opa_eff,
  output logic [63:0] o_opb_eff,
  output fsc_pkg::fsc_class_t o_opa_class,
  output fsc_pkg::fsc_class_t o_opb_class,
  output logic [12:0] o_opa_exp_unb,
  output logic [12:0] o_opb_exp_unb,
  // configuration seen by the datapaths
  output fsc_pkg::fsc_round_t o_round_select_field,
  output logic o_flush_denormal_ctl,
  output logic [7:0] o_compare_condition_bits,
  output logic [31:0] o_qnan_word,
  output logic [63:0] o_qnan_long
);
  import fsc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // register fields and decode of the pieces

  logic [7:0] cc_r;
  logic fs_r;
  logic [5:0] cause_r;
  logic [4:0] enable_r;
  logic [4:0] flag_r;
  logic [1:0] rm_r;
  logic [7:0] cc_nxt;
  logic [4:0] flag_nxt;
  logic [31:0] reg_image;
  logic [7:0] wr_cc;
  logic [5:0] wr_cause;
  logic [4:0] wr_enable;
  logic fp_op;
  logic arith_op;
  logic unimpl;
  logic [5:0] op_cause;
  logic op_trap;
  logic wr_trap;
  logic state_trap;
  fsc_rd_state_t rd_state_r;

  // fields of a move-control write, condition bits gathered into one byte
  assign wr_cc = {i_move_ctl_to_fpu_data[`FSC_CC_HI_LSB +: `FSC_CC_HI_W],
                  i_move_ctl_to_fpu_data[`FSC_CC0_BIT]};
  assign wr_cause = i_move_ctl_to_fpu_data[`FSC_CAUSE_LSB +: `FSC_CAUSE_W];
  assign wr_enable = i_move_ctl_to_fpu_data[`FSC_EN_LSB +: `FSC_EN_W];

  // register image; bits 22:18 read as zero
  always_comb
  begin
    reg_image = 32'h0;
    reg_image[`FSC_CC_HI_LSB +: `FSC_CC_HI_W] = cc_r[7:1]; // RULE_05
    reg_image[`FSC_FS_BIT] = fs_r;
    reg_image[`FSC_CC0_BIT] = cc_r[0];
    reg_image[`FSC_CAUSE_LSB +: `FSC_CAUSE_W] = cause_r; // RULE_25
    reg_image[`FSC_EN_LSB +: `FSC_EN_W] = enable_r;
    reg_image[`FSC_FLAG_LSB +: `FSC_FLAG_W] = flag_r;
    reg_image[`FSC_RM_LSB +: `FSC_RM_W] = rm_r;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // exception cause of the completing operation

  // moves, loads and stores are no fp operation for cause purposes
  assign fp_op = i_op_done && (i_op_kind != FSC_OP_MOVE); // RULE_08
  assign arith_op = i_op_done && (i_op_kind == FSC_OP_ARITH); // RULE_04

  // emulation needed: datapath says so, unflushed denormal result, or denormal product
  always_comb
  begin
    unimpl = i_op_exc[`FSC_CAUSE_UNIMPL]; // RULE_09
    if (arith_op && i_op_res_denorm && !fs_r)
      unimpl = 1'b1; // RULE_01
    if (arith_op && i_op_fma_mul_denorm)
      unimpl = 1'b1; // RULE_23
  end

  assign op_cause = {unimpl, i_op_exc[4:0]}; // RULE_07 RULE_25

  // result flush unless a denormal product forces the unimplemented trap
  assign o_flush_result_zero = arith_op && i_op_res_denorm && fs_r
                               && !i_op_fma_mul_denorm; // RULE_01

  // trap decision for the operation, for a write, and for the held state
  fsc_trap_eval u_op_trap
  (
    .i_cause(op_cause),
    .i_enable(enable_r),
    .o_trap(op_trap)
  );

  fsc_trap_eval u_wr_trap
  (
    .i_cause(wr_cause),
    .i_enable(wr_enable),
    .o_trap(wr_trap)
  );

  fsc_trap_eval u_state_trap
  (
    .i_cause(cause_r),
    .i_enable(enable_r),
    .o_trap(state_trap)
  );

  // exception is raised in the completing cycle, not a cycle later
  assign o_fp_trap = (fp_op && op_trap) || (i_move_ctl_to_fpu && wr_trap); // RULE_11 RULE_12
  // stays up until the handler clears the enabled causes by a write
  assign o_trap_pending = state_trap; // RULE_13
  // a trapping operation stores nothing; untrapped ones store the default result
  assign o_dest_wr_en = i_op_done && i_op_writes_dest && !(fp_op && op_trap); // RULE_10 RULE_14

  ////////////////////////////////////////////////////////////////////////////////
  // control fields written by move-control only

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      fs_r <= `FSC_RST_FS;
      enable_r <= `FSC_RST_EN;
      rm_r <= `FSC_RST_RM;
    end
    else if (i_move_ctl_to_fpu)
    begin
      fs_r <= i_move_ctl_to_fpu_data[`FSC_FS_BIT];
      enable_r <= wr_enable;
      rm_r <= i_move_ctl_to_fpu_data[`FSC_RM_LSB +: `FSC_RM_W]; // RULE_17
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // cause field: an fp op in the same cycle as a write wins, being later in order

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      cause_r <= `FSC_RST_CAUSE;
    else if (fp_op)
      cause_r <= op_cause; // RULE_07 RULE_08
    else if (i_move_ctl_to_fpu)
      cause_r <= wr_cause;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sticky flags: a set from an operation survives a same-cycle clearing write

  always_comb
  begin
    flag_nxt = i_move_ctl_to_fpu ? i_move_ctl_to_fpu_data[`FSC_FLAG_LSB +: `FSC_FLAG_W] : flag_r;
    if (fp_op && !op_trap)
      flag_nxt = flag_nxt | op_cause[4:0]; // RULE_15 RULE_16
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      flag_r <= `FSC_RST_FLAG;
    else
      flag_r <= flag_nxt; // RULE_15
  end

  ////////////////////////////////////////////////////////////////////////////////
  // condition bits: a write lays the base, an untrapped compare sets its one bit

  always_comb
  begin
    cc_nxt = i_move_ctl_to_fpu ? wr_cc : cc_r; // RULE_06
    if (i_op_done && i_op_kind == FSC_OP_COMPARE && !op_trap)
      cc_nxt[i_op_cc_sel] = i_op_cc_true; // RULE_05
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      cc_r <= `FSC_RST_CC;
    else
      cc_r <= cc_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // move-control read: waits for the pipeline to drain, then answers; a trap completing during the wait asks for retry at once

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      rd_state_r <= FSC_RD_IDLE;
    else
    begin
      unique case (rd_state_r)
        FSC_RD_IDLE:
          if (i_move_ctl_from_fpu)
            rd_state_r <= FSC_RD_WAIT;
        FSC_RD_WAIT:
          if (fp_op && op_trap)
            rd_state_r <= FSC_RD_IDLE; // RULE_24
          else if (!i_ops_pending && !i_op_done)
            rd_state_r <= FSC_RD_IDLE; // RULE_24
      endcase
    end
  end

  // answers are registered so the data word never glitches
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      o_move_ctl_from_fpu_valid <= 1'b0;
      o_move_ctl_from_fpu_retry <= 1'b0;
      o_move_ctl_from_fpu_data <= 32'h0;
    end
    else
    begin
      o_move_ctl_from_fpu_valid <= 1'b0;
      o_move_ctl_from_fpu_retry <= 1'b0;
      if (rd_state_r == FSC_RD_WAIT)
      begin
        if (fp_op && op_trap)
          o_move_ctl_from_fpu_retry <= 1'b1; // RULE_24
        else if (!i_ops_pending && !i_op_done)
        begin
          o_move_ctl_from_fpu_valid <= 1'b1;
          o_move_ctl_from_fpu_data <= reg_image;
        end
      end
    end
  end

  assign o_move_ctl_from_fpu_busy = (rd_state_r == FSC_RD_WAIT);

  ////////////////////////////////////////////////////////////////////////////////
  // operand classification; flushing gated to arithmetic so moves pass untouched

  fsc_operand_class u_class_a
  (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_valid(i_opnd_valid),
    .i_double(i_opnd_double),
    .i_flush_en(fs_r && i_opnd_arith), // RULE_03 RULE_04
    .i_operand(i_opa),
    .o_valid(o_opnd_valid),
    .o_class(o_opa_class),
    .o_sign(),
    .o_exp_unb(o_opa_exp_unb),
    .o_operand(o_opa_eff)
  );

  fsc_operand_class u_class_b
  (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_valid(i_opnd_valid),
    .i_double(i_opnd_double),
    .i_flush_en(fs_r && i_opnd_arith), // RULE_03 RULE_04
    .i_operand(i_opb),
    .o_valid(),
    .o_class(o_opb_class),
    .o_sign(),
    .o_exp_unb(o_opb_exp_unb),
    .o_operand(o_opb_eff)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // configuration outputs, registered from the fields and the integer nan constants

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      o_round_select_field <= FSC_ROUND_NEAREST_EVEN;
      o_flush_denormal_ctl <= `FSC_RST_FS;
      o_compare_condition_bits <= `FSC_RST_CC;
      o_qnan_word <= `FSC_QNAN_WORD;
      o_qnan_long <= `FSC_QNAN_LONG;
    end
    else
    begin
      o_round_select_field <= fsc_round_t'(rm_r); // RULE_17
      o_flush_denormal_ctl <= fs_r;
      o_compare_condition_bits <= cc_r;
      o_qnan_word <= `FSC_QNAN_WORD; // RULE_22
      o_qnan_long <= `FSC_QNAN_LONG; // RULE_22
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  a_cause_rewrite: assert property (fp_op |=> cause_r == $past(op_cause)) // RULE_07
    else $error("cause not rewritten by fp operation");
  a_move_keeps_cause: assert property (
    (i_op_done && i_op_kind == FSC_OP_MOVE && !i_move_ctl_to_fpu) |=> $stable(cause_r)) // RULE_08
    else $error("move changed cause field");
  a_flush_no_unimpl: assert property (
    (arith_op && i_op_res_denorm && fs_r && !i_op_fma_mul_denorm && !i_op_exc[5])
    |-> (!unimpl && o_flush_result_zero)) // RULE_01
    else $error("flushed result still raised unimplemented");
  a_fma_unimpl: assert property ((arith_op && i_op_fma_mul_denorm) |-> o_fp_trap) // RULE_23
    else $error("denormal product did not trap");
  a_unimpl_traps: assert property ((fp_op && unimpl) |-> (o_fp_trap && !o_dest_wr_en)) // RULE_12
    else $error("unimplemented cause did not trap");
  a_write_trap: assert property (
    (i_move_ctl_to_fpu && |(wr_cause[4:0] & wr_enable)) |-> o_fp_trap
    ##1 o_trap_pending) // RULE_11
    else $error("enabled cause written without exception");
  a_trap_no_dest: assert property ((fp_op && op_trap) |-> !o_dest_wr_en) // RULE_10
    else $error("destination written on trap");
  a_no_trap_store: assert property (
    (fp_op && !unimpl && ~|(i_op_exc[4:0] & enable_r) && i_op_writes_dest)
    |-> (o_dest_wr_en && !o_fp_trap)) // RULE_14
    else $error("unenabled cause trapped or dropped result");
  a_flag_sticky: assert property (!i_move_ctl_to_fpu |=> (flag_r & $past(flag_r)) == $past(flag_r)) // RULE_15
    else $error("flag cleared by operation");
  a_trap_no_flag: assert property ((fp_op && op_trap && !i_move_ctl_to_fpu) |=> $stable(flag_r)) // RULE_16
    else $error("flags updated on trap");
  a_cc_only: assert property (
    (!i_move_ctl_to_fpu && !(i_op_done && i_op_kind == FSC_OP_COMPARE)) |=> $stable(cc_r)) // RULE_06
    else $error("condition bits changed without compare or write");
  a_cc_write: assert property (
    (i_op_done && i_op_kind == FSC_OP_COMPARE && !op_trap && !i_move_ctl_to_fpu)
    |=> cc_r[$past(i_op_cc_sel)] == $past(i_op_cc_true)) // RULE_05
    else $error("compare result not stored");
  a_read_waits: assert property (o_move_ctl_from_fpu_valid |-> !$past(i_ops_pending)) // RULE_24
    else $error("control read answered while ops pending");

  c_op_trap: cover property (fp_op && op_trap);
  c_flush: cover property (o_flush_result_zero ##1 !o_trap_pending);
  c_read_retry: cover property (o_move_ctl_from_fpu_busy ##[1:20] o_move_ctl_from_fpu_retry);
  c_read_ok: cover property (i_move_ctl_from_fpu ##[1:20] o_move_ctl_from_fpu_valid);

endmodule : fsc_status

// >>> fsc_status_test.sv
// fsc_status_test.sv: self-checking bench for the fp control/status block
// assumes the design files and fsc_pipe_model.sv are compiled first
module fsc_status_test;
  timeunit 1ns;
  timeprecision 1ns;
  import fsc_pkg::*;
  logic clk = 1'h0, rstn = 1'h0, wr = 1'h0, rq = 1'h0, oval = 1'h0, odbl = 1'h0, oar = 1'h0;
  logic busy, vld, rty, pend, done, tpend, ov, fsb;
  logic [31:0] wd = '0, rdat, qw;
  logic [63:0] qa = '0, qb = '0, ea, eb, ql;
  logic [11:0] info;
  logic [7:0] ccb;
  logic [12:0] xa, xb;
  wire logic [2:0] ans;
  fsc_op_kind_t kind;
  fsc_class_t ca, cb;
  fsc_round_t rmf;
  int n_errors = 0, samples_checked = 0;
  // 50 MHz clock
  always #10 clk = ~clk;
  fsc_status uut (.i_clock(clk), .i_rstn(rstn), .i_move_ctl_to_fpu(wr),
    .i_move_ctl_to_fpu_data(wd), .i_move_ctl_from_fpu(rq), .o_move_ctl_from_fpu_busy(busy),
    .o_move_ctl_from_fpu_valid(vld), .o_move_ctl_from_fpu_retry(rty),
    .o_move_ctl_from_fpu_data(rdat), .i_ops_pending(pend), .i_op_done(done),
    .i_op_kind(kind), .i_op_exc(info[8:3]), .i_op_res_denorm(info[2]),
    .i_op_fma_mul_denorm(info[1]), .i_op_writes_dest(kind != FSC_OP_COMPARE),
    .i_op_cc_sel(info[11:9]),
    .i_op_cc_true(info[0]), .o_fp_trap(ans[2]), .o_trap_pending(tpend),
    .o_dest_wr_en(ans[1]), .o_flush_result_zero(ans[0]), .i_opnd_valid(oval),
    .i_opnd_double(odbl), .i_opnd_arith(oar), .i_opa(qa), .i_opb(qb), .o_opnd_valid(ov),
    .o_opa_eff(ea), .o_opb_eff(eb), .o_opa_class(ca), .o_opb_class(cb), .o_opa_exp_unb(xa),
    .o_opb_exp_unb(xb), .o_round_select_field(rmf), .o_flush_denormal_ctl(fsb),
    .o_compare_condition_bits(ccb), .o_qnan_word(qw), .o_qnan_long(ql));
  fsc_pipe_model pipe (.i_clock(clk), .i_answer(ans), .o_ops_pending(pend), .o_op_done(done),
    .o_op_kind(kind), .o_op_info(info));
  ////////////////////////////////////////////////////////////////////////////////
  // compare and count; case inequality so an unknown never passes
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  // register write; trap answer sampled in the strobe cycle, config outputs settle after
  task wrt(input logic [31:0] d, output logic t);
    wr = 1'h1;
    wd = d;
    #1 t = ans[2];
    @(negedge clk);
    wr = 1'h0;
    @(negedge clk);
  endtask : wrt
  // register read; bounded wait for valid or retry
  task rd(input logic [31:0] exp, input logic exp_retry);
    int n;
    rq = 1'h1;
    @(negedge clk);
    rq = 1'h0;
    n = 0;
    while (vld !== 1'h1 && rty !== 1'h1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    // a read that never answers must not pass on stale data
    chk({vld, rty}, {~exp_retry, exp_retry});
    if (!exp_retry)
      chk(rdat, exp);
  endtask : rd
  // info packs {cc_sel, exc, res_denorm, fma_denorm, cc_true}; answer is {trap, dest, flush}
  task op(input fsc_op_kind_t k, input logic [11:0] i, input logic [2:0] exp);
    logic [2:0] a;
    pipe.issue(k, i, a);
    // idle cycle so the done strobe is never lowered and raised in one step
    @(negedge clk);
    chk(a, exp);
  endtask : op
  // operand pair, results one cycle later
  task opnd(input logic d, input logic a, input logic [63:0] x, input logic [63:0] y);
    {oval, odbl, oar, qa, qb} = {1'h1, d, a, x, y};
    @(negedge clk);
    oval = 1'h0;
    chk(ov, 1'h1);
    @(negedge clk);
  endtask : opnd
  task tally_and_finish();
    $display("checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog: the whole sequence needs well under 1000 cycles
  initial
  begin
    repeat (3000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end
  // main sequence, inputs change at falling edges
  initial
  begin
    logic t;
    repeat (4) @(negedge clk);
    rstn = 1'h1;
    rd(32'h0, 1'h0);
    chk(ql, 64'h7fffffffffffffff);
    chk(qw, 32'h7fffffff);
    for (int m = 0; m < 4; m++)
    begin
      wrt(m[31:0], t);
      chk(rmf, m[1:0]);
    end
    $display("test reset and rounding done");
    // flushing on with underflow and inexact enables clear; bits 22:18 ignored
    wrt(32'hff7c0003, t);
    rd(32'hff000003, 1'h0);
    chk(fsb, 1'h1);
    op(FSC_OP_COMPARE, 12'he00, 3'h0);
    op(FSC_OP_COMPARE, 12'h001, 3'h0);
    op(FSC_OP_ARITH, 12'h008, 3'h2);
    op(FSC_OP_MOVE, 12'h010, 3'h2);
    @(negedge clk);
    chk(ccb, 8'h7f);
    rd(32'h7f801007, 1'h0);
    op(FSC_OP_ARITH, 12'h010, 3'h2);
    rd(32'h7f80200f, 1'h0);
    $display("test condition and flag done");
    op(FSC_OP_ARITH, 12'h004, 3'h3);
    op(FSC_OP_CONVERT, 12'h004, 3'h2);
    op(FSC_OP_ARITH, 12'h006, 3'h4);
    chk(tpend, 1'h1);
    wrt(32'h0, t);
    chk(tpend, 1'h0);
    op(FSC_OP_ARITH, 12'h004, 3'h4);
    wrt(32'h0, t);
    wrt(32'h200, t);
    op(FSC_OP_ARITH, 12'h020, 3'h4);
    rd(32'h4200, 1'h0);
    wrt(32'h4200, t);
    chk(t, 1'h1);
    wrt(32'h0, t);
    $display("test trap done");
    // a trapping op completes while the read waits for the pipeline to drain
    pipe.o_ops_pending = 1'h1;
    fork
      rd(32'h0, 1'h1);
      begin
        repeat (3) @(negedge clk);
        chk(busy, 1'h1);
        op(FSC_OP_ARITH, 12'h100, 3'h4);
        pipe.o_ops_pending = 1'h0;
      end
    join
    wrt(32'h0, t);
    rd(32'h0, 1'h0);
    wrt(32'h01000000, t);
    opnd(1'h0, 1'h1, 64'h1, 64'h7f800000);
    chk(ea, 64'h0);
    chk(ca, FSC_CLS_DENORM);
    chk(cb, FSC_CLS_INF);
    opnd(1'h0, 1'h0, 64'h1, 64'h7fc00000);
    chk(ea, 64'h1);
    chk(cb, FSC_CLS_SNAN);
    opnd(1'h0, 1'h1, 64'h40000000, 64'h7f800001);
    chk(xa, 13'h0001);
    chk(cb, FSC_CLS_QNAN);
    opnd(1'h1, 1'h1, 64'h4000000000000000, 64'h8000000000000001);
    chk(xa, 13'h0001);
    chk(eb, 64'h8000000000000000);
    chk(xb, 13'h1c02);
    $display("test retry and operand done");
    tally_and_finish();
  end
endmodule : fsc_status_test

// >>> fsc_trap_eval.sv
// fsc_trap_eval.sv: decides whether a cause vector raises an fp exception
// assumes cause and enable come in the control/status field order
`include "fsc_consts.svh"
module fsc_trap_eval
(
  // cause and enable fields
  input wire logic [5:0] i_cause,
  input wire logic [4:0] i_enable,
  // result
  output logic o_trap
);
  import fsc_pkg::*;

  // unimplemented has no enable and always traps
  assign o_trap = i_cause[`FSC_CAUSE_UNIMPL] | (|(i_cause[4:0] & i_enable)); // RULE_11 RULE_12

endmodule : fsc_trap_eval
